/* design/hsdp_pkg.sv */
// shared constants and types of the host serial datagram port
// assumes a single device clock mclk at 40 mhz and an async high reset
package hsdp_pkg;

  // datagram geometry
  localparam int DGRAM_BITS = 32;
  localparam int CNT_W = 6;
  localparam logic [5:0] CNT_FULL = 6'h20;
  localparam logic [5:0] CNT_OVER = 6'h21;

  // device clock and reply timing
  localparam int MCLK_HZ = 40000000;
  localparam int SYNC_STAGES = 2;
  localparam int TSD_MIN_CLK = 4;
  localparam int OUT_WAIT_CYC = (TSD_MIN_CLK - SYNC_STAGES) < 1 ? 1 :
                                (TSD_MIN_CLK - SYNC_STAGES);
  localparam logic [2:0] OUT_WAIT = 3'(OUT_WAIT_CYC);

  // receive buffer
  localparam int FIFO_DEPTH = 8;

  // values after reset
  localparam logic [3:0] PREDIV_RESET = 4'hF;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  localparam logic [2:0] SYNC_RESET = 3'h7;

  // bit positions inside the synchroniser vector
  localparam int SYN_SCLK = 0;
  localparam int SYN_SEL = 1;
  localparam int SYN_SDI = 2;

  // incoming datagram layout, msb first on the wire
  typedef struct packed {
    logic ram_select;
    logic [5:0] address;
    logic read_not_write;
    logic [23:0] data;
  } dgram_t;

  // reply datagram: status in the top byte, read data below
  typedef struct packed {
    logic [7:0] status;
    logic [23:0] data;
  } reply_t;

endpackage

/* design/host_serial_datagram_port.sv */
// serial slave port for host datagrams with a receive fifo
// assumes the host is spi master with sclk idle high, select low active
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////
// generic fifo with valid and ready on both sides
module hsdp_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] DEPTH_CNT = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  // handshake terms from the fill level
  assign in_ready = (cnt_q != DEPTH_CNT);
  assign out_valid = (cnt_q != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_q];

  // pointer and level update
  always_comb begin
    wr_d = wr_q;
    rd_d = rd_q;
    cnt_d = cnt_q;
    if (push) begin
      wr_d = (wr_q == LAST_IDX) ? '0 : wr_q + 1'b1;
    end
    if (pop) begin
      rd_d = (rd_q == LAST_IDX) ? '0 : rd_q + 1'b1;
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // storage, no reset needed
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////
// host side serial slave: shift in, buffer, reply, interrupt mux
module host_serial_datagram_port (
  input wire logic mclk,
  input wire logic reset,
  input wire logic host_sclk,
  input wire logic host_select_n,
  input wire logic host_sdi,
  output logic host_out_irq_shared,
  output logic host_out_tristate,
  output logic host_out_tristate_oe,
  input wire logic irq_n,
  input wire logic irq_direct_mode,
  input wire hsdp_pkg::reply_t reply_word,
  output hsdp_pkg::dgram_t dgram_data,
  output logic dgram_valid,
  input wire logic dgram_ready,
  output logic dgram_dropped,
  output logic frame_error,
  input wire logic predivider_load,
  input wire logic [3:0] predivider_value,
  output logic [3:0] spi_clock_predivider
);

  logic [2:0] sync1_q, sync2_q, sync3_q;
  logic sclk_rise, sclk_fall, sel_fall, sel_rise, selected;
  logic [31:0] rx_q, rx_d, tx_q, tx_d;
  logic [5:0] cnt_q, cnt_d;
  logic [2:0] wait_q, wait_d;
  logic bit_q, bit_d;
  logic [3:0] prediv_q, prediv_d;
  logic drop_q, drop_d, ferr_q, ferr_d;
  logic push_valid, push_ready;

  ////////////////////////////////////////////////////////////////////
  // two flip-flop synchronisers, edges taken from the second stage
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      sync1_q <= hsdp_pkg::SYNC_RESET;
      sync2_q <= hsdp_pkg::SYNC_RESET;
      sync3_q <= hsdp_pkg::SYNC_RESET;
    end else begin
      sync1_q <= {host_sdi, host_select_n, host_sclk};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // edge terms of the synchronised levels
  assign selected = !sync2_q[hsdp_pkg::SYN_SEL];
  assign sclk_rise = sync2_q[hsdp_pkg::SYN_SCLK] && !sync3_q[hsdp_pkg::SYN_SCLK];
  assign sclk_fall = !sync2_q[hsdp_pkg::SYN_SCLK] && sync3_q[hsdp_pkg::SYN_SCLK];
  assign sel_fall = selected && sync3_q[hsdp_pkg::SYN_SEL];
  assign sel_rise = !selected && !sync3_q[hsdp_pkg::SYN_SEL];

  ////////////////////////////////////////////////////////////////////
  // receive shift, bit count, reply shift and output timing
  always_comb begin
    rx_d = rx_q;
    tx_d = tx_q;
    cnt_d = cnt_q;
    wait_d = wait_q;
    bit_d = bit_q;
    drop_d = 1'b0;
    ferr_d = 1'b0;
    if (sel_fall) begin
      cnt_d = '0;
      tx_d = reply_word;
      wait_d = '0;
    end else if (selected) begin
      if (sclk_rise) begin
        rx_d = {rx_q[30:0], sync2_q[hsdp_pkg::SYN_SDI]};
        if (cnt_q != hsdp_pkg::CNT_OVER) begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      if (sclk_fall) begin
        wait_d = hsdp_pkg::OUT_WAIT;
      end else if (wait_q != '0) begin
        wait_d = wait_q - 1'b1;
      end
      if (wait_q == 3'h1) begin
        bit_d = tx_q[31];
        tx_d = {tx_q[30:0], 1'b0};
      end
    end
    if (sel_rise) begin
      if (cnt_q != hsdp_pkg::CNT_FULL) begin
        ferr_d = (cnt_q != '0);
      end else if (!push_ready) begin
        drop_d = 1'b1;
      end
      wait_d = '0;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rx_q <= hsdp_pkg::WORD_RESET;
      tx_q <= hsdp_pkg::WORD_RESET;
      cnt_q <= '0;
      wait_q <= '0;
      bit_q <= 1'b0;
      drop_q <= 1'b0;
      ferr_q <= 1'b0;
    end else begin
      rx_q <= rx_d;
      tx_q <= tx_d;
      cnt_q <= cnt_d;
      wait_q <= wait_d;
      bit_q <= bit_d;
      drop_q <= drop_d;
      ferr_q <= ferr_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // clock predivider setting, loads fifteen at reset
  always_comb begin
    prediv_d = prediv_q;
    if (predivider_load) begin
      prediv_d = predivider_value;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      prediv_q <= hsdp_pkg::PREDIV_RESET;
    end else begin
      prediv_q <= prediv_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // buffer register: complete datagrams go into the fifo, or are dropped when it is full
  assign push_valid = sel_rise && (cnt_q == hsdp_pkg::CNT_FULL);

  hsdp_fifo #(
    .WIDTH(hsdp_pkg::DGRAM_BITS),
    .DEPTH(hsdp_pkg::FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .reset(reset),
    .in_data(rx_q),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .out_data(dgram_data),
    .out_valid(dgram_valid),
    .out_ready(dgram_ready)
  );

  ////////////////////////////////////////////////////////////////////
  // output pins and status outputs
  assign host_out_irq_shared = (irq_direct_mode || !selected) ? irq_n : bit_q;
  assign host_out_tristate = bit_q;
  assign host_out_tristate_oe = selected;
  assign dgram_dropped = drop_q;
  assign frame_error = ferr_q;
  assign spi_clock_predivider = prediv_q;

  ////////////////////////////////////////////////////////////////////
  // checks and covers
  a_tristate_float: assert property (@(posedge mclk) disable iff (reset)
    host_select_n |-> ##2 !host_out_tristate_oe)
    else $error("tristate output driven while deselected");

  a_tristate_reply: assert property (@(posedge mclk) disable iff (reset)
    (host_out_tristate_oe && !irq_direct_mode) |-> host_out_tristate == host_out_irq_shared)
    else $error("tristate output differs from reply bit");

  a_irq_direct: assert property (@(posedge mclk) disable iff (reset)
    irq_direct_mode |-> host_out_irq_shared == irq_n)
    else $error("direct mode does not carry interrupt");

  a_irq_idle: assert property (@(posedge mclk) disable iff (reset)
    host_select_n ##2 host_select_n |-> host_out_irq_shared == irq_n)
    else $error("idle shared pin does not carry interrupt");

  a_shift_in: assert property (@(posedge mclk) disable iff (reset)
    (selected && sclk_rise && !sel_fall) |=> rx_q[0] == $past(sync2_q[2])
      && rx_q[31:1] == $past(rx_q[30:0]))
    else $error("input bit not shifted on sclk rise");

  a_out_delay: assert property (@(posedge mclk) disable iff (reset)
    (selected && sclk_fall) |=> $stable(bit_q) ##1 (selected -> $stable(bit_q)))
    else $error("reply bit changed too soon after sclk fall");

  a_buffer_push: assert property (@(posedge mclk) disable iff (reset)
    (sel_rise && cnt_q == 6'h20 && push_ready && !dgram_ready) |=> dgram_valid
      && ($past(dgram_valid) || dgram_data == $past(rx_q)))
    else $error("complete datagram not buffered");

  a_no_partial: assert property (@(posedge mclk) disable iff (reset)
    (sel_rise && cnt_q != 6'h20) |=> !(dgram_valid && !$past(dgram_valid)))
    else $error("partial datagram buffered");

  a_count_clear: assert property (@(posedge mclk) disable iff (reset)
    sel_fall |=> cnt_q == 6'h00)
    else $error("bit counter not cleared on select fall");

  a_predivider_reset: assert property (@(posedge mclk)
    reset |=> (reset || predivider_load || $past(predivider_load)
      || spi_clock_predivider == 4'hF))
    else $error("predivider not fifteen after reset");

  c_full_datagram: cover property (@(posedge mclk) disable iff (reset) push_valid && push_ready);
  c_fifo_full: cover property (@(posedge mclk) disable iff (reset) drop_q);
  c_frame_error: cover property (@(posedge mclk) disable iff (reset) ferr_q);
  c_direct_mode: cover property (@(posedge mclk) disable iff (reset) irq_direct_mode && selected);

endmodule

/* testbench/hsdp_host_model.sv */
// host spi master model driving the serial pins of the port
// assumes pins change at falling mclk, sclk idles high
`timescale 1ns/1ps

module hsdp_host_model (
  input wire logic mclk,
  output logic host_sclk,
  output logic host_select_n,
  output logic host_sdi,
  input wire logic host_out_irq_shared,
  input wire logic host_out_tristate
);

  // idle levels
  initial begin
    host_sclk = 1'h1;
    host_select_n = 1'h1;
    host_sdi = 1'h0;
  end

  ////////////////////////////////////////////////////////////////////////
  // one frame of nbits, msb first, reply taken at each sclk rise
  task automatic xfer(input logic [31:0] tx, input int nbits,
                      output logic [31:0] rx, output logic [31:0] rx_sh);
    logic [31:0] sh;
    sh = tx;
    rx = 32'h0;
    rx_sh = 32'h0;
    repeat (4) @(negedge mclk);
    host_select_n <= 1'h0;
    repeat (3) @(negedge mclk);
    for (int i = 0; i < nbits; i++) begin
      host_sclk <= 1'h0;
      host_sdi <= sh[31];
      sh = {sh[30:0], sh[31]};
      repeat (6) @(negedge mclk);
      host_sclk <= 1'h1;
      rx = {rx[30:0], host_out_tristate};
      rx_sh = {rx_sh[30:0], host_out_irq_shared};
      repeat (6) @(negedge mclk);
    end
    host_select_n <= 1'h1;
    host_sdi <= ~host_sdi; // released line keeps no level
  endtask

endmodule

/* testbench/host_serial_datagram_port_tb.sv */
// self-checking bench of the host serial datagram port
// assumes the host model drives the pins, bench drives the user side
`timescale 1ns/1ps

module host_serial_datagram_port_tb;
  logic mclk, reset, host_sclk, host_select_n, host_sdi;
  logic host_out_irq_shared, host_out_tristate, host_out_tristate_oe;
  logic irq_n, irq_direct_mode, dgram_valid, dgram_ready, dgram_dropped;
  logic frame_error, predivider_load;
  logic [3:0] predivider_value, spi_clock_predivider;
  logic [31:0] rx, rx_sh;
  hsdp_pkg::reply_t reply_word;
  hsdp_pkg::dgram_t dgram_data;
  int mismatches, total_checks, cycles, fe_cnt, drop_cnt, oe_cnt, base;

  host_serial_datagram_port dut_u (.mclk(mclk), .reset(reset), .host_sclk(host_sclk),
    .host_select_n(host_select_n), .host_sdi(host_sdi),
    .host_out_irq_shared(host_out_irq_shared), .host_out_tristate(host_out_tristate),
    .host_out_tristate_oe(host_out_tristate_oe), .irq_n(irq_n),
    .irq_direct_mode(irq_direct_mode), .reply_word(reply_word), .dgram_data(dgram_data),
    .dgram_valid(dgram_valid), .dgram_ready(dgram_ready), .dgram_dropped(dgram_dropped),
    .frame_error(frame_error), .predivider_load(predivider_load),
    .predivider_value(predivider_value), .spi_clock_predivider(spi_clock_predivider));

  hsdp_host_model host_u (.mclk(mclk), .host_sclk(host_sclk),
    .host_select_n(host_select_n), .host_sdi(host_sdi),
    .host_out_irq_shared(host_out_irq_shared), .host_out_tristate(host_out_tristate));

  ////////////////////////////////////////////////////////////////////////
  // clock, pulse counters and hang guard
  initial begin
    mclk = 1'h0;
    forever #12.5 mclk = ~mclk;
  end

  always @(negedge mclk) begin
    if (frame_error === 1'h1) fe_cnt++;
    if (dgram_dropped === 1'h1) drop_cnt++;
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      end_sim;
    end
  end

  always @(posedge host_sclk) if (host_out_tristate_oe === 1'h1) oe_cnt++;

  ////////////////////////////////////////////////////////////////////////
  // compare, pop and verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic pop(input logic [31:0] exp);
    check(dgram_valid, 32'h1, "head valid");
    check(dgram_data, exp, "head word");
    dgram_ready = 1'h1;
    @(negedge mclk);
    dgram_ready = 1'h0;
    @(negedge mclk);
  endtask

  task automatic end_sim;
    if (mismatches == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset;
    check(spi_clock_predivider, 32'hF, "predivider reset");
    check(dgram_valid, 32'h0, "valid after reset");
    check(host_out_tristate_oe, 32'h0, "oe idle");
    irq_n = 1'h0;
    @(negedge mclk);
    check(host_out_irq_shared, 32'h0, "irq low idle");
    irq_n = 1'h1;
    @(negedge mclk);
    check(host_out_irq_shared, 32'h1, "irq high idle");
    predivider_value = 4'h6;
    predivider_load = 1'h1;
    @(negedge mclk);
    predivider_load = 1'h0;
    check(spi_clock_predivider, 32'h6, "predivider load");
  endtask

  task automatic t_basic;
    reply_word = 32'hA5C3_0F96;
    irq_n = 1'h0;
    oe_cnt = 0;
    host_u.xfer(32'h8123_4567, 32, rx, rx_sh);
    repeat (4) @(negedge mclk);
    check(rx, 32'hA5C3_0F96, "reply bits");
    check(rx_sh, 32'hA5C3_0F96, "shared reply");
    check(32'(oe_cnt), 32'd32, "oe during frame");
    check(host_out_tristate_oe, 32'h0, "oe after frame");
    check(host_out_irq_shared, 32'h0, "irq after frame");
    pop(32'h8123_4567);
    irq_n = 1'h1;
  endtask

  task automatic t_direct;
    irq_direct_mode = 1'h1;
    irq_n = 1'h0;
    reply_word = 32'h5A3C_F069;
    host_u.xfer(32'h0000_0001, 32, rx, rx_sh);
    repeat (4) @(negedge mclk);
    check(rx, 32'h5A3C_F069, "tristate reply");
    check(rx_sh, 32'h0, "irq on shared");
    pop(32'h0000_0001);
    irq_direct_mode = 1'h0;
    irq_n = 1'h1;
  endtask

  task automatic t_short;
    base = fe_cnt;
    host_u.xfer(32'hFFFF_FFFF, 31, rx, rx_sh);
    host_u.xfer(32'h0123_4567, 33, rx, rx_sh);
    repeat (4) @(negedge mclk);
    check(32'(fe_cnt - base), 32'd2, "bad frames flagged");
    check(dgram_valid, 32'h0, "bad frames dropped");
    host_u.xfer(32'h7654_3210, 32, rx, rx_sh);
    repeat (4) @(negedge mclk);
    pop(32'h7654_3210);
  endtask

  task automatic t_fifo;
    base = drop_cnt;
    for (int i = 0; i < 9; i++) host_u.xfer(32'h1000_0000 + i, 32, rx, rx_sh);
    repeat (4) @(negedge mclk);
    check(32'(drop_cnt - base), 32'd1, "full fifo drop");
    for (int i = 0; i < 8; i++) pop(32'h1000_0000 + i);
    check(dgram_valid, 32'h0, "fifo empty");
  endtask

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    reset = 1'h1;
    irq_n = 1'h1;
    irq_direct_mode = 1'h0;
    reply_word = 32'h0;
    dgram_ready = 1'h0;
    predivider_load = 1'h0;
    predivider_value = 4'h0;
    repeat (16) @(negedge mclk);
    reset = 1'h0;
    t_reset;
    t_basic;
    t_direct;
    t_short;
    t_fifo;
    end_sim;
  end

endmodule
